/* File: hdl/wdr_pkg.sv */
package wdr_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0]  CTRL_IDX       = 6'h21;
    localparam logic [5:0]  CAUSE_IDX      = 6'h34;
    localparam int          ADDR_W         = 8;

    // control register field positions
    localparam int          CTRL_IRQ_FLAG  = 7;
    localparam int          CTRL_IRQ_EN    = 6;
    localparam int          CTRL_PSEL_MSB  = 5;
    localparam int          CTRL_CHG_EN    = 4;
    localparam int          CTRL_WD_EN     = 3;

    // reset-cause register field positions
    localparam int          CAUSE_WDOG     = 3;
    localparam int          CAUSE_BROWN    = 2;
    localparam int          CAUSE_PIN      = 1;
    localparam int          CAUSE_POWERON  = 0;

    // reset values
    localparam logic [3:0]  CAUSE_RST_VAL  = 4'h1;
    localparam logic [3:0]  PSEL_RST_VAL   = 4'h0;

    // timing
    localparam int          SYS_CLK_HZ     = 50_000_000;
    localparam int          WDOG_OSC_HZ    = 128_000;
    localparam int          OSC_DIV_CYC    = SYS_CLK_HZ / WDOG_OSC_HZ;
    localparam int          CHG_WIN_CYC    = 4;
    localparam int          BASE_TIMEOUT   = 2048;
    localparam logic [3:0]  PSEL_MAX       = 4'h9;
    localparam int          WDOG_CNT_W     = 21;

    // watchdog control state
    typedef struct packed {
        logic       irq_flag;
        logic       irq_en;
        logic       chg_en;
        logic       wd_en;
        logic [3:0] psel;
    } wdr_ctrl_type;

    // reset-cause flags
    typedef struct packed {
        logic wdog;
        logic brown;
        logic pin;
        logic poweron;
    } wdr_cause_type;

endpackage

/* File: hdl/wdr_watchdog.sv */
// The implementer's own choice: register access over Avalon-MM.
module wdr_watchdog
    import wdr_pkg::*;
#(
    parameter int OSC_DIV   = OSC_DIV_CYC,
    parameter int BASE_TICK = BASE_TIMEOUT
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic [ADDR_W-1:0] i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic [31:0]            o_avs_readdata,
    output logic                   o_avs_waitrequest,
    input  wire logic              i_brownout_reset,
    input  wire logic              i_pin_reset,
    input  wire logic              i_safety_level_fuse,
    input  wire logic              i_global_irq_enable,
    input  wire logic              i_irq_vector_taken,
    input  wire logic              i_watchdog_restart,
    output logic                   o_timeout_irq,
    output logic                   o_watchdog_reset
);

    localparam logic [WDOG_CNT_W-1:0] BASE_CNT = WDOG_CNT_W'(BASE_TICK);
    localparam logic [9:0]            DIV_LAST = 10'(OSC_DIV - 1);
    localparam logic [2:0]            CHG_LAST = 3'(CHG_WIN_CYC);

    wdr_ctrl_type            ctrl_r;
    wdr_cause_type           cause_r;
    logic                    ack_r;
    logic [31:0]             rdata_r;
    logic [2:0]              chg_cnt_r;
    logic [9:0]              div_r;
    logic                    tick;
    logic [WDOG_CNT_W-1:0]   wd_cnt_r;
    logic [WDOG_CNT_W-1:0]   limit;
    logic [3:0]              psel_eff;
    logic                    rst_pulse_r;
    logic [1:0]              brown_sync_r;
    logic [1:0]              pin_sync_r;
    logic [1:0]              fuse_sync_r;
    logic                    level2;
    logic                    wd_en_eff;
    logic                    running;
    logic                    timeout;
    logic                    chip_rst;
    logic                    req;
    logic                    wr_ctrl;
    logic                    wr_cause;
    logic                    rd_hit_ctrl;
    logic                    rd_hit_cause;
    logic [7:0]              wbyte;
    logic                    arm_chg;

    // two-stage synchronisers for the reset pins
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            brown_sync_r <= 2'h0;
            pin_sync_r   <= 2'h0;
        end else begin
            brown_sync_r <= {brown_sync_r[0], i_brownout_reset};
            pin_sync_r   <= {pin_sync_r[0], i_pin_reset};
        end
    end

    // the static fuse strap is sampled through reset too, so level two holds
    // from the first cycle after release instead of two cycles later
    always_ff @(posedge i_clk) begin
        fuse_sync_r <= {fuse_sync_r[0], i_safety_level_fuse};
    end

    // bus decode; every access answers on the second edge
    assign req          = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~ack_r;
    assign wbyte        = i_avs_writedata[7:0];
    assign wr_ctrl      = i_avs_write & ack_r & i_avs_byteenable[0]
                          & (i_avs_address[7:2] == CTRL_IDX);
    assign wr_cause     = i_avs_write & ack_r & i_avs_byteenable[0]
                          & (i_avs_address[7:2] == CAUSE_IDX);
    assign rd_hit_ctrl  = i_avs_address[7:2] == CTRL_IDX;
    assign rd_hit_cause = i_avs_address[7:2] == CAUSE_IDX;

    // ack toggles so a held request sees exactly one completion edge
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // read data captured in the wait cycle, stands at the completing edge
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdata_r <= 32'h0;
        end else if (i_avs_read & ~ack_r) begin
            if (rd_hit_ctrl) begin
                rdata_r <= {24'h0, ctrl_r.irq_flag, ctrl_r.irq_en, ctrl_r.psel[3],
                            ctrl_r.chg_en, wd_en_eff, ctrl_r.psel[2:0]};
            end else if (rd_hit_cause) begin
                rdata_r <= {28'h0, cause_r};
            end else begin
                rdata_r <= 32'h0;
            end
        end
    end
    assign o_avs_readdata = rdata_r;

    // safety level and effective enable
    assign level2    = fuse_sync_r[1];
    assign wd_en_eff = ctrl_r.wd_en | level2 | cause_r.wdog;
    assign running   = wd_en_eff | ctrl_r.irq_en;
    assign chip_rst  = brown_sync_r[1] | pin_sync_r[1] | rst_pulse_r;
    assign arm_chg   = wr_ctrl & wbyte[CTRL_CHG_EN] & wbyte[CTRL_WD_EN];

    // reserved codes clamp to the longest period
    assign psel_eff = (ctrl_r.psel > PSEL_MAX) ? PSEL_MAX : ctrl_r.psel;
    assign limit    = BASE_CNT << psel_eff;

    // oscillator-rate tick from the system clock; a divider keeps one domain
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || div_r == DIV_LAST) begin
            div_r <= 10'h0;
        end else begin
            div_r <= div_r + 10'h1;
        end
    end
    assign tick = div_r == DIV_LAST;

    // timeout counter
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || chip_rst || i_watchdog_restart || !running) begin
            wd_cnt_r <= '0;
        end else if (tick) begin
            wd_cnt_r <= timeout ? '0 : wd_cnt_r + 1'b1;
        end
    end
    assign timeout = running & tick & (wd_cnt_r == limit - 1'b1);

    // one-cycle reset pulse in reset mode
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rst_pulse_r <= 1'b0;
        end else begin
            rst_pulse_r <= timeout & wd_en_eff & ~ctrl_r.irq_en & ~rst_pulse_r;
        end
    end
    assign o_watchdog_reset = rst_pulse_r;

    // change window counter; closes four cycles after arming
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || chip_rst) begin
            chg_cnt_r <= 3'h0;
        end else if (arm_chg) begin
            chg_cnt_r <= CHG_LAST;
        end else if (chg_cnt_r != 3'h0) begin
            chg_cnt_r <= chg_cnt_r - 3'h1;
        end
    end

    // control register; hardware sets win over software clears
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || chip_rst) begin
            ctrl_r.irq_flag <= 1'b0;
            ctrl_r.irq_en   <= 1'b0;
            ctrl_r.chg_en   <= 1'b0;
            ctrl_r.wd_en    <= 1'b0;
            ctrl_r.psel     <= PSEL_RST_VAL;
        end else begin
            // flag: timeout sets, vector or one-write clears
            if (timeout & ctrl_r.irq_en) begin
                ctrl_r.irq_flag <= 1'b1;
            end else if (i_irq_vector_taken | (wr_ctrl & wbyte[CTRL_IRQ_FLAG])) begin
                ctrl_r.irq_flag <= 1'b0;
            end
            // a write in the timeout cycle re-arms the interrupt on purpose
            if (wr_ctrl) begin
                ctrl_r.irq_en <= wbyte[CTRL_IRQ_EN];
            end else if (timeout & wd_en_eff & ctrl_r.irq_en) begin
                ctrl_r.irq_en <= 1'b0;
            end
            if (arm_chg) begin
                ctrl_r.chg_en <= 1'b1;
            end else if (wr_ctrl & ~wbyte[CTRL_CHG_EN]) begin
                ctrl_r.chg_en <= 1'b0;
            end else if (chg_cnt_r == 3'h1) begin
                ctrl_r.chg_en <= 1'b0;
            end
            // setting is free; clearing needs the open window
            if (wr_ctrl & (wbyte[CTRL_WD_EN] | ctrl_r.chg_en)) begin
                ctrl_r.wd_en <= wbyte[CTRL_WD_EN];
            end
            if (wr_ctrl & ctrl_r.chg_en) begin
                ctrl_r.psel <= {wbyte[CTRL_PSEL_MSB], wbyte[2:0]};
            end
        end
    end
    assign o_timeout_irq = ctrl_r.irq_flag & ctrl_r.irq_en & i_global_irq_enable;

    // reset-cause flags survive chip resets; block reset acts as power-on
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cause_r <= CAUSE_RST_VAL;
        end else begin
            cause_r.wdog    <= rst_pulse_r | (cause_r.wdog
                               & ~(wr_cause & ~wbyte[CAUSE_WDOG]));
            cause_r.brown   <= brown_sync_r[1] | (cause_r.brown
                               & ~(wr_cause & ~wbyte[CAUSE_BROWN]));
            cause_r.pin     <= pin_sync_r[1] | (cause_r.pin
                               & ~(wr_cause & ~wbyte[CAUSE_PIN]));
            cause_r.poweron <= cause_r.poweron
                               & ~(wr_cause & ~wbyte[CAUSE_POWERON]);
        end
    end

    // checks
    sequence s_arm;
        arm_chg;
    endsequence

    // no control write completes for four cycles, so nothing may shorten the window
    sequence s_quiet;
        (!wr_ctrl) [*4];
    endsequence

    // window still open on its fourth cycle and shut on the fifth
    sequence s_window;
        ctrl_r.chg_en ##1 !ctrl_r.chg_en;
    endsequence

    a_cause_rsvd_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (ack_r && i_avs_read && rd_hit_cause) |-> (o_avs_readdata[31:4] == 28'h0))
        else $error("reset-cause upper bits not zero");
    a_wdog_flag_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        rst_pulse_r |=> cause_r.wdog)
        else $error("watchdog cause flag not set");
    a_brown_flag_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        brown_sync_r[1] |=> cause_r.brown)
        else $error("brown-out cause flag not set");
    a_pin_flag_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        pin_sync_r[1] |=> cause_r.pin)
        else $error("pin cause flag not set");
    a_poweron_keep: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cause_r.poweron && !wr_cause) |=> cause_r.poweron)
        else $error("power-on flag lost without a write");
    a_chg_window_len: assert property (@(posedge i_clk) disable iff (!i_rst_n || chip_rst)
        s_arm ##1 s_quiet |-> s_window)
        else $error("change window length wrong");
    a_wd_en_guard: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wr_ctrl && !ctrl_r.chg_en && wd_en_eff && !chip_rst) |=> wd_en_eff)
        else $error("watchdog disabled outside window");
    a_psel_locked: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wr_ctrl && !ctrl_r.chg_en && !chip_rst) |=> $stable(ctrl_r.psel))
        else $error("prescaler changed outside window");
    a_level2_forced: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        level2 |-> (running && wd_en_eff))
        else $error("level two watchdog not enabled");
    a_level1_forced: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        cause_r.wdog |-> running)
        else $error("watchdog stopped while cause flag set");
    a_irq_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_timeout_irq |-> (i_global_irq_enable && ctrl_r.irq_flag && ctrl_r.irq_en))
        else $error("interrupt without its enables");
    a_irq_en_drop: assert property (@(posedge i_clk) disable iff (!i_rst_n || chip_rst)
        (timeout && wd_en_eff && ctrl_r.irq_en && !wr_ctrl) |=> !ctrl_r.irq_en)
        else $error("interrupt enable not cleared");
    a_rst_one_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_watchdog_reset |=> (!o_watchdog_reset && wd_cnt_r == '0))
        else $error("reset pulse longer than one cycle");

    // register map and read path
    a_read_upper_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (ack_r && i_avs_read) |-> (o_avs_readdata[31:8] == 24'h0))
        else $error("read data above the low byte not zero");
    a_level2_reads_on: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (level2 && ack_r && i_avs_read && rd_hit_ctrl) |-> o_avs_readdata[CTRL_WD_EN])
        else $error("level two enable reads zero");

    // reset-cause clears; a set in the same cycle would win, so it is left out
    a_wdog_flag_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wr_cause && !wbyte[CAUSE_WDOG] && !rst_pulse_r) |=> !cause_r.wdog)
        else $error("watchdog cause flag not cleared");
    a_brown_flag_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wr_cause && !wbyte[CAUSE_BROWN] && !brown_sync_r[1]) |=> !cause_r.brown)
        else $error("brown-out cause flag not cleared");
    a_pin_flag_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wr_cause && !wbyte[CAUSE_PIN] && !pin_sync_r[1]) |=> !cause_r.pin)
        else $error("pin cause flag not cleared");
    a_poweron_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wr_cause && !wbyte[CAUSE_POWERON]) |=> !cause_r.poweron)
        else $error("power-on flag not cleared");

    // change window, interrupt flag and timeout actions
    a_chg_open: assert property (@(posedge i_clk) disable iff (!i_rst_n || chip_rst)
        s_arm |=> ctrl_r.chg_en)
        else $error("change window did not open");
    a_irq_flag_set: assert property (@(posedge i_clk) disable iff (!i_rst_n || chip_rst)
        (timeout && ctrl_r.irq_en) |=> ctrl_r.irq_flag)
        else $error("interrupt flag not set on timeout");
    a_irq_flag_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_irq_vector_taken && !timeout) |=> !ctrl_r.irq_flag)
        else $error("interrupt flag kept after vector");
    a_timeout_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (timeout && wd_en_eff && !ctrl_r.irq_en && !rst_pulse_r) |=> o_watchdog_reset)
        else $error("reset-mode timeout gave no reset");
    a_stopped_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!running || i_watchdog_restart) |=> (wd_cnt_r == '0))
        else $error("counter not restarted");
    a_psel_clamp: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (ctrl_r.psel > PSEL_MAX) |-> (limit == (BASE_CNT << PSEL_MAX)))
        else $error("reserved prescaler code not clamped");

endmodule

/* File: tb/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import wdr_pkg::*;

    logic              i_clk   = 1'b0;
    logic              i_rst_n = 1'b0;
    logic [ADDR_W-1:0] adr     = '0;
    logic              rd_s    = 1'b0;
    logic              wr_s    = 1'b0;
    logic [31:0]       wdat    = '0;
    logic [3:0]        be      = 4'h1;
    logic [31:0]       rdat;
    logic              wait_s;
    logic              bo      = 1'b0;
    logic              pin     = 1'b0;
    logic              fuse    = 1'b0;
    logic              gie     = 1'b0;
    logic              vec     = 1'b0;
    logic              rst_q   = 1'b0;
    logic              wprev   = 1'b0;
    logic              irq;
    logic              wrst;
    logic [7:0]        exp_q[$];
    int                err_count = 0;
    int                cmp_count = 0;
    int                cyc       = 0;
    int                rst_seen  = 0;

    // 50 MHz system clock
    always #10 i_clk = ~i_clk;

    // short counts keep every timeout within a few thousand cycles
    wdr_watchdog #(.OSC_DIV(2), .BASE_TICK(4)) wdr_watchdog_i (
        .i_clk               (i_clk),
        .i_rst_n             (i_rst_n),
        .i_avs_address       (adr),
        .i_avs_read          (rd_s),
        .i_avs_write         (wr_s),
        .i_avs_writedata     (wdat),
        .i_avs_byteenable    (be),
        .o_avs_readdata      (rdat),
        .o_avs_waitrequest   (wait_s),
        .i_brownout_reset    (bo),
        .i_pin_reset         (pin),
        .i_safety_level_fuse (fuse),
        .i_global_irq_enable (gie),
        .i_irq_vector_taken  (vec),
        .i_watchdog_restart  (rst_q),
        .o_timeout_irq       (irq),
        .o_watchdog_reset    (wrst)
    );

    task automatic give_verdict();
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one Avalon access; waitrequest is sampled at each rising edge and the
    // request is dropped only after the edge at which it is seen low
    task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
        @(posedge i_clk);
        adr  <= {idx, 2'b00};
        wdat <= {24'($urandom()), d};
        rd_s <= ~w;
        wr_s <= w;
        do @(posedge i_clk); while (wait_s !== 1'b0);
        rd_s <= 1'b0;
        wr_s <= 1'b0;
    endtask

    // the note goes in first, the monitor takes it when the data stands
    task automatic rd(input logic [5:0] idx, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, idx, 8'h00);
    endtask

    // monitor: read results, reset pulse width and the run's ceiling
    always @(posedge i_clk) begin
        if (rd_s && wait_s === 1'b0) begin
            chk(rdat[7:0], exp_q.pop_front());
        end
        if (wrst === 1'b1) begin
            rst_seen++;
        end
        if (wrst === 1'b1 && wprev) begin
            chk(8'h01, 8'h00);
        end
        wprev <= (wrst === 1'b1);
        cyc++;
        if (cyc > 30000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        int         n;
        logic [5:0] ux;
        void'($urandom(10));
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        // unmapped place reads zero and swallows writes
        ux = 6'($urandom());
        if (ux == CTRL_IDX || ux == CAUSE_IDX) begin
            ux = 6'h00;
        end
        bus(1'b1, ux, 8'hff);
        rd(ux, 8'h00);
        rd(CTRL_IDX, 8'h00);
        rd(CAUSE_IDX, 8'h01);
        bus(1'b1, CAUSE_IDX, 8'hff);
        rd(CAUSE_IDX, 8'h01);
        // a write without the low byte lane enabled is ignored
        be <= 4'he;
        bus(1'b1, CAUSE_IDX, 8'hf0);
        be <= 4'h1;
        rd(CAUSE_IDX, 8'h01);
        bus(1'b1, CAUSE_IDX, 8'hf0);
        rd(CAUSE_IDX, 8'h00);
        // pin reset, then brown-out; each leaves its own flag
        for (int i = 0; i < 2; i++) begin
            @(posedge i_clk);
            pin <= (i == 0);
            bo  <= (i == 1);
            repeat (4) @(posedge i_clk);
            pin <= 1'b0;
            bo  <= 1'b0;
            repeat (5) @(posedge i_clk);
            rd(CAUSE_IDX, (i == 1) ? 8'h06 : 8'h02);
        end
        // interrupt mode, longest period set inside the change window
        gie <= 1'b1;
        bus(1'b1, CTRL_IDX, 8'h18);
        bus(1'b1, CTRL_IDX, 8'h61);
        rd(CTRL_IDX, 8'h61);
        while (irq !== 1'b1) @(negedge i_clk);
        rd(CTRL_IDX, 8'he1);
        @(posedge i_clk);
        gie <= 1'b0;
        @(negedge i_clk);
        chk({7'h0, irq}, 8'h00);
        @(posedge i_clk);
        gie <= 1'b1;
        @(negedge i_clk);
        chk({7'h0, irq}, 8'h01);
        bus(1'b1, CTRL_IDX, 8'he1);
        rd(CTRL_IDX, 8'h61);
        while (irq !== 1'b1) @(negedge i_clk);
        @(posedge i_clk);
        vec <= 1'b1;
        @(posedge i_clk);
        vec <= 1'b0;
        @(negedge i_clk);
        chk({7'h0, irq}, 8'h00);
        // combined mode: first timeout drops irq enable, second resets
        bus(1'b1, CTRL_IDX, 8'h69);
        repeat (5000) @(posedge i_clk);
        rd(CTRL_IDX, 8'ha9);
        while (wrst !== 1'b1) @(negedge i_clk);
        rd(CTRL_IDX, 8'h08);
        rd(CAUSE_IDX, 8'h0e);
        // restart held so the counter never expires from here on
        @(posedge i_clk);
        rst_q <= 1'b1;
        repeat (20) @(posedge i_clk);
        n = rst_seen;
        bus(1'b1, CAUSE_IDX, 8'h00);
        rd(CTRL_IDX, 8'h00);
        bus(1'b1, CTRL_IDX, 8'h09);
        rd(CTRL_IDX, 8'h08);
        bus(1'b1, CTRL_IDX, 8'h00);
        rd(CTRL_IDX, 8'h08);
        bus(1'b1, CTRL_IDX, 8'h18);
        rd(CTRL_IDX, 8'h18);
        repeat (4) @(posedge i_clk);
        bus(1'b1, CTRL_IDX, 8'h00);
        rd(CTRL_IDX, 8'h08);
        bus(1'b1, CTRL_IDX, 8'h18);
        bus(1'b1, CTRL_IDX, 8'h00);
        rd(CTRL_IDX, 8'h00);
        // a reserved prescaler code is accepted inside the window and kept
        bus(1'b1, CTRL_IDX, 8'h18);
        bus(1'b1, CTRL_IDX, 8'h27);
        rd(CTRL_IDX, 8'h27);
        chk(8'(rst_seen - n), 8'h00);
        // safety level two: enabled from reset and never disabled
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        fuse    <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(CTRL_IDX, 8'h08);
        bus(1'b1, CTRL_IDX, 8'h18);
        bus(1'b1, CTRL_IDX, 8'h00);
        rd(CTRL_IDX, 8'h08);
        give_verdict();
    end
endmodule
